// >>> hdl/tcc_top.sv
// 16-bit capture/compare timer with its free-running counter, APB slave
// assumes pclk 200 MHz, port pins arrive asynchronous to pclk
`timescale 1ns/1ps
`include "tcc_regs.svh"

module tcc_top (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // port pins
  input  wire logic        port_a_bit2_pin,
  output logic             port_a_bit3_pin_out,
  output logic             port_a_bit3_pin_oe,
  // interrupt request
  output logic             timer_irq
);

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------

  // true when a word address lands on a given register index
  function automatic logic hit(input logic [7:0] a,
                               input logic [5:0] i);
    hit = (a[1:0] == 2'h0) && (a[7:2] == i);
  endfunction : hit

  logic        pready_reg;
  logic        acc;
  logic        rd;
  logic        wr;
  logic [7:0]  wbyte;

  // two-cycle transfer: pready rises in the access phase
  assign acc   = psel & penable & pready_reg;
  assign rd    = acc & ~pwrite;
  assign wr    = acc & pwrite;
  assign wbyte = pwdata[7:0];

  logic rd_flags;
  logic rd_cap_hi;
  logic rd_cap_lo;
  logic wr_cmp_hi;
  logic acc_cmp_lo;
  logic acc_cnt_lo;

  // accesses with side effects
  assign rd_flags   = rd & hit(paddr, `TCC_IDX_FLAGS);
  assign rd_cap_hi  = rd & hit(paddr, `TCC_IDX_CAP_HI);
  assign rd_cap_lo  = rd & hit(paddr, `TCC_IDX_CAP_LO);
  assign wr_cmp_hi  = wr & hit(paddr, `TCC_IDX_CMP_HI);
  assign acc_cmp_lo = acc & hit(paddr, `TCC_IDX_CMP_LO);
  assign acc_cnt_lo = acc & hit(paddr, `TCC_IDX_CNT_LO);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0]          presc_reg;
  logic                tick;
  logic [15:0]         cnt_reg;
  logic [15:0]         cap_val_reg;
  logic [15:0]         cmp_val_reg;
  logic                cap_block_reg;
  logic                cmp_block_reg;
  logic                edge_sel_reg;
  tcc_pkg::tcc_ctrl_type  ctrl_reg;
  tcc_pkg::tcc_flags_type flags_reg;
  tcc_pkg::tcc_flags_type arm_reg;
  tcc_pkg::tcc_pinfn_type pinfn_reg;
  logic                cap_sync1_reg;
  logic                cap_sync2_reg;
  logic                cap_in;
  logic                cap_in_d_reg;
  logic                cap_edge;
  logic                cap_fire;
  logic                cmp_fire;
  logic                ovf_fire;
  logic                cmp_latch_reg;

  // ---------------------------------------------------------------
  // prescaler and free-running counter
  // ---------------------------------------------------------------

  // divide by four gives the counter step enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 2'h0;
    end else begin
      presc_reg <= presc_reg + 2'h1; // [RULE3]
    end
  end

  assign tick = (presc_reg == `TCC_PRESC_LAST);

  // counter wraps naturally from all ones to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= `TCC_CNT_RST;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001; // [RULE3]
    end
  end

  assign ovf_fire = tick && (cnt_reg == `TCC_CNT_TOP); // [RULE21]

  // ---------------------------------------------------------------
  // capture input path
  // ---------------------------------------------------------------

  // two-stage synchroniser on the asynchronous pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_sync1_reg <= 1'b1;
      cap_sync2_reg <= 1'b1;
    end else begin
      cap_sync1_reg <= port_a_bit2_pin;
      cap_sync2_reg <= cap_sync1_reg;
    end
  end

  // disabled pin function holds the capture input high
  assign cap_in = pinfn_reg.cap_pen ? cap_sync2_reg : 1'b1; // [RULE19]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_in_d_reg <= 1'b1;
    end else begin
      cap_in_d_reg <= cap_in;
    end
  end

  // edge polarity: one picks rising, zero picks falling
  assign cap_edge = edge_sel_reg ? (cap_in & ~cap_in_d_reg)
                                 : (~cap_in & cap_in_d_reg); // [RULE17]
  assign cap_fire = cap_edge & ~cap_block_reg; // [RULE4]

  // capture block: high-byte read holds off until low-byte read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_block_reg <= 1'b0;
    end else if (rd_cap_lo) begin
      cap_block_reg <= 1'b0; // [RULE4]
    end else if (rd_cap_hi) begin
      cap_block_reg <= 1'b1; // [RULE4]
    end
  end

  // the capture pair has no reset; sync delay is paid by the +1
  always_ff @(posedge pclk) begin
    if (cap_fire) begin
      cap_val_reg <= cnt_reg + 16'h0001; // [RULE1] [RULE2] [RULE5] [RULE6]
    end
  end

  // ---------------------------------------------------------------
  // compare path
  // ---------------------------------------------------------------

  // compare pair: software only, kept through reset
  always_ff @(posedge pclk) begin
    if (wr && hit(paddr, `TCC_IDX_CMP_HI)) begin
      cmp_val_reg[15:8] <= wbyte; // [RULE13]
    end
    if (wr && hit(paddr, `TCC_IDX_CMP_LO)) begin
      cmp_val_reg[7:0] <= wbyte; // [RULE13]
    end
  end

  // high-byte write inhibits matches until the low byte lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_block_reg <= 1'b0;
    end else if (wr && hit(paddr, `TCC_IDX_CMP_LO)) begin
      cmp_block_reg <= 1'b0; // [RULE10]
    end else if (wr_cmp_hi) begin
      cmp_block_reg <= 1'b1; // [RULE10]
    end
  end

  // compare only on counter steps so a match fires once per count
  assign cmp_fire = tick && !cmp_block_reg
                    && (cnt_reg == cmp_val_reg); // [RULE9] [RULE10]

  // level reaches the latch even if the flag is already set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_latch_reg <= 1'b0;
    end else if (cmp_fire) begin
      cmp_latch_reg <= ctrl_reg.level; // [RULE9] [RULE12] [RULE18]
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------

  // enables and level bit, all cleared by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= '0; // [RULE15] [RULE16] [RULE18]
    end else if (wr && hit(paddr, `TCC_IDX_CTRL)) begin
      ctrl_reg.cap_ie <= wbyte[`TCC_BIT_CAP_IE]; // [RULE16]
      ctrl_reg.cmp_ie <= wbyte[`TCC_BIT_CMP_IE];
      ctrl_reg.ovf_ie <= wbyte[`TCC_BIT_OVF_IE];
      ctrl_reg.level  <= wbyte[`TCC_BIT_LEVEL];
    end
  end

  // edge select survives reset, so it has no reset branch
  always_ff @(posedge pclk) begin
    if (wr && hit(paddr, `TCC_IDX_CTRL)) begin
      edge_sel_reg <= wbyte[`TCC_BIT_EDGE]; // [RULE15]
    end
  end

  // pin function enables, cleared at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pinfn_reg <= '0; // [RULE19] [RULE20]
    end else if (wr && hit(paddr, `TCC_IDX_PINFN)) begin
      pinfn_reg.cap_pen <= wbyte[`TCC_BIT_CAP_PEN];
      pinfn_reg.cmp_pen <= wbyte[`TCC_BIT_CMP_PEN];
    end
  end

  // ---------------------------------------------------------------
  // status flags and their arming
  // ---------------------------------------------------------------

  // a status read arms each flag that was set when read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg <= '0;
    end else begin
      if (rd_flags) begin
        arm_reg <= flags_reg;
      end else begin
        if (rd_cap_lo) arm_reg.cap <= 1'b0;
        if (acc_cmp_lo) arm_reg.cmp <= 1'b0;
        if (acc_cnt_lo) arm_reg.ovf <= 1'b0;
      end
    end
  end

  // flags ignore reset and writes; a new event beats the clear
  always_ff @(posedge pclk) begin
    if (cap_fire) begin
      flags_reg.cap <= 1'b1; // [RULE7]
    end else if (arm_reg.cap && rd_cap_lo) begin
      flags_reg.cap <= 1'b0; // [RULE8]
    end
    if (cmp_fire) begin
      flags_reg.cmp <= 1'b1; // [RULE23]
    end else if (arm_reg.cmp && acc_cmp_lo) begin
      flags_reg.cmp <= 1'b0; // [RULE11]
    end
    if (ovf_fire) begin
      flags_reg.ovf <= 1'b1; // [RULE21]
    end else if (arm_reg.ovf && acc_cnt_lo) begin
      flags_reg.ovf <= 1'b0; // [RULE24]
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------

  // pin drive and enable come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_bit3_pin_out <= 1'b0;
      port_a_bit3_pin_oe  <= 1'b0;
    end else begin
      port_a_bit3_pin_out <= cmp_latch_reg;
      port_a_bit3_pin_oe  <= pinfn_reg.cmp_pen; // [RULE20]
    end
  end

  // one interrupt line, each flag gated by its enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (flags_reg.cap & ctrl_reg.cap_ie)
                 | (flags_reg.cmp & ctrl_reg.cmp_ie)
                 | (flags_reg.ovf & ctrl_reg.ovf_ie); // [RULE16]
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  logic [7:0] rbyte;
  logic       mapped;

  // read mux; flag writes fall through as no-ops
  always_comb begin
    rbyte  = 8'h00;
    mapped = 1'b1;
    if (hit(paddr, `TCC_IDX_CTRL)) begin
      rbyte[`TCC_BIT_CAP_IE] = ctrl_reg.cap_ie;
      rbyte[`TCC_BIT_CMP_IE] = ctrl_reg.cmp_ie;
      rbyte[`TCC_BIT_OVF_IE] = ctrl_reg.ovf_ie;
      rbyte[`TCC_BIT_EDGE]   = edge_sel_reg;
      rbyte[`TCC_BIT_LEVEL]  = ctrl_reg.level;
    end else if (hit(paddr, `TCC_IDX_FLAGS)) begin
      rbyte[`TCC_BIT_CAP_F] = flags_reg.cap; // [RULE22]
      rbyte[`TCC_BIT_CMP_F] = flags_reg.cmp;
      rbyte[`TCC_BIT_OVF_F] = flags_reg.ovf;
    end else if (hit(paddr, `TCC_IDX_CAP_HI)) begin
      rbyte = cap_val_reg[15:8]; // [RULE6]
    end else if (hit(paddr, `TCC_IDX_CAP_LO)) begin
      rbyte = cap_val_reg[7:0];
    end else if (hit(paddr, `TCC_IDX_CMP_HI)) begin
      rbyte = cmp_val_reg[15:8]; // [RULE13]
    end else if (hit(paddr, `TCC_IDX_CMP_LO)) begin
      rbyte = cmp_val_reg[7:0];
    end else if (hit(paddr, `TCC_IDX_CNT_HI)) begin
      rbyte = cnt_reg[15:8];
    end else if (hit(paddr, `TCC_IDX_CNT_LO)) begin
      rbyte = cnt_reg[7:0];
    end else if (hit(paddr, `TCC_IDX_PINFN)) begin
      rbyte[`TCC_BIT_CAP_PEN] = pinfn_reg.cap_pen;
      rbyte[`TCC_BIT_CMP_PEN] = pinfn_reg.cmp_pen;
    end else begin
      mapped = 1'b0;
    end
  end

  // answer loads in setup, stands for the one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else if (psel && !penable && !pready_reg) begin
      pready_reg <= 1'b1;
      prdata     <= {24'h00_0000, pwrite ? 8'h00 : rbyte};
      pslverr    <= ~mapped;
    end else begin
      pready_reg <= 1'b0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end
  end

  assign pready = pready_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // a status read of a set flag, then an armed flag and a low-byte read, each with no new capture in that cycle
  sequence s_cap_armed;
    rd_flags && flags_reg.cap && !cap_fire;
  endsequence
  sequence s_cap_clear;
    arm_reg.cap && rd_cap_lo && !cap_fire;
  endsequence
  sequence s_cmp_hold;
    wr_cmp_hi ##1 !(wr && hit(paddr, `TCC_IDX_CMP_LO));
  endsequence

  a_tick_every_four: assert property ( // [RULE3]
    tick |=> !tick [*3] ##1 tick)
    else $error("counter step not every four clocks");
  a_cap_value_plus: assert property ( // [RULE1] [RULE2]
    cap_fire |=> cap_val_reg == $past(cnt_reg) + 16'h0001)
    else $error("capture value wrong");
  a_cap_held_block: assert property ( // [RULE4]
    cap_block_reg && !rd_cap_lo |=> $stable(cap_val_reg))
    else $error("capture taken while blocked");
  a_cap_flag_set: assert property ( // [RULE7]
    cap_fire |=> flags_reg.cap)
    else $error("capture flag not set");
  a_cap_flag_arm: assert property ( // [RULE8]
    s_cap_armed |=> arm_reg.cap)
    else $error("capture flag not armed by status read");
  a_cap_flag_clear: assert property ( // [RULE8]
    s_cap_clear |=> !flags_reg.cap)
    else $error("capture flag not cleared");
  a_cmp_pin_level: assert property ( // [RULE9] [RULE12]
    cmp_fire |=> ##1 port_a_bit3_pin_out == $past(ctrl_reg.level, 2))
    else $error("compare level not driven");
  a_cmp_inhibit: assert property ( // [RULE10]
    s_cmp_hold |-> !cmp_fire)
    else $error("compare fired while inhibited");
  a_ovf_flag_set: assert property ( // [RULE21]
    tick && cnt_reg == `TCC_CNT_TOP |=> flags_reg.ovf && cnt_reg == 16'h0)
    else $error("overflow not flagged");
  a_irq_gating: assert property ( // [RULE16]
    ##1 timer_irq == $past((flags_reg.cap & ctrl_reg.cap_ie)
                         | (flags_reg.cmp & ctrl_reg.cmp_ie)
                         | (flags_reg.ovf & ctrl_reg.ovf_ie)))
    else $error("interrupt gating wrong");
  a_cap_pin_off: assert property ( // [RULE19]
    !pinfn_reg.cap_pen [*2] |-> !cap_fire)
    else $error("capture seen from disabled pin");
  a_cmp_pin_off: assert property ( // [RULE20]
    !pinfn_reg.cmp_pen |=> !port_a_bit3_pin_oe)
    else $error("compare pin driven while disabled");

endmodule : tcc_top

// >>> pkg/tcc_pkg.sv
// types shared by the capture/compare timer
// assumes the constants header supplies all numbers
package tcc_pkg;

  // control bits that reset clears
  typedef struct packed {
    logic cap_ie;
    logic cmp_ie;
    logic ovf_ie;
    logic level;
  } tcc_ctrl_type;

  // sticky event flags, never reset
  typedef struct packed {
    logic cap;
    logic cmp;
    logic ovf;
  } tcc_flags_type;

  // pin function enables
  typedef struct packed {
    logic cap_pen;
    logic cmp_pen;
  } tcc_pinfn_type;

endpackage : tcc_pkg

// >>> pkg/tcc_regs.svh
// register indices, field positions, reset values and timing counts
// assumes APB byte address = 4 * index, data in the low byte
//
// Behaviour
// RULE1: active capture edge copies counter into capture pair
// RULE2: captured value is one above prior count
// RULE3: counter steps once per four bus clocks
// RULE4: high capture read blocks captures until low read
// RULE5: capture pair always holds latest capture
// RULE6: capture pair read-only, untouched by reset
// RULE7: capture edge sets capture flag, reset-proof
// RULE8: status read then capture-low read clears flag
// RULE9: each counter step compares, match drives level
// RULE10: compare-high write inhibits compares until low write
// RULE11: status read then compare-low access clears flag
// RULE12: match drives pin latch whatever compare flag
// RULE13: compare pair read/write, kept through reset
// RULE14: software sequence for safe compare update
// RULE15: reset clears control except edge select
// RULE16: three interrupt enables gate flags, reset clears
// RULE17: edge select one rising, zero falling
// RULE18: level bit one high, zero low, reset clears
// RULE19: capture pin enable off holds capture high
// RULE20: compare pin enable off disconnects compare pin
// RULE21: status flags, overflow on ffff to zero
// RULE22: status writes ignored, reset keeps flags
// RULE23: match sets compare flag, reset-proof
// RULE24: status read then counter-low access clears overflow
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define TCC_IDX_CTRL     6'h12
`define TCC_IDX_FLAGS    6'h13
`define TCC_IDX_CAP_HI   6'h14
`define TCC_IDX_CAP_LO   6'h15
`define TCC_IDX_CMP_HI   6'h16
`define TCC_IDX_CMP_LO   6'h17
`define TCC_IDX_CNT_HI   6'h18
`define TCC_IDX_CNT_LO   6'h19
`define TCC_IDX_PINFN    6'h1a

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TCC_BIT_CAP_IE   7
`define TCC_BIT_CMP_IE   6
`define TCC_BIT_OVF_IE   5
`define TCC_BIT_EDGE     1
`define TCC_BIT_LEVEL    0
`define TCC_BIT_CAP_F    7
`define TCC_BIT_CMP_F    6
`define TCC_BIT_OVF_F    5
`define TCC_BIT_CAP_PEN  0
`define TCC_BIT_CMP_PEN  1

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define TCC_CNT_RST      16'hfffc
`define TCC_CNT_TOP      16'hffff
`define TCC_PRESC_LAST   2'h3

`endif

// >>> test/tcc_pin_model.sv
// far side of the timer pins: drives the capture pin, resolves compare pin
// assumes pclk is the bench clock; requests change only after an edge
`timescale 1ns/1ps

module tcc_pin_model (
  // clock
  input  wire logic pclk,
  // capture pin request from the bench and the pin itself
  input  wire logic cap_req,
  output logic      cap_pin,
  // compare pin drive from the timer and the resolved wire
  input  wire logic cmp_out,
  input  wire logic cmp_oe,
  output logic      cmp_wire
);
  logic float_reg = 1'b0;

  // ----------------------------------------------------------
  // pin behaviour
  // ----------------------------------------------------------
  // the event source moves only just after a clock edge
  initial cap_pin = 1'b1;
  always @(posedge pclk) begin
    cap_pin   <= cap_req;
    float_reg <= ~float_reg;
  end

  // an undriven pin wanders, so a missing drive never reads as a level
  assign cmp_wire = cmp_oe ? cmp_out : float_reg;
endmodule : tcc_pin_model

// >>> test/testbench.sv
// self-checking bench for the capture/compare timer over apb
// assumes the timer answers each apb access within a few cycles
`timescale 1ns/1ps
`include "tcc_regs.svh"

`define CHK(g, e) \
  checks_done++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); \
  end

module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, d, pre, c, c2, th;
  logic [31:0] pwdata, prdata;
  logic        cap_pin, pin_out, pin_oe, timer_irq, cap_req, cmp_wire, err;
  logic [15:0] t;
  int          bad_count, checks_done, cycles;

  tcc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_bit2_pin(cap_pin),
    .port_a_bit3_pin_out(pin_out), .port_a_bit3_pin_oe(pin_oe),
    .timer_irq(timer_irq)
  );

  tcc_pin_model u_pins (
    .pclk(pclk), .cap_req(cap_req), .cap_pin(cap_pin),
    .cmp_out(pin_out), .cmp_oe(pin_oe), .cmp_wire(cmp_wire)
  );

  // ----------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // the longest wait is about 1100 cycles; the ceiling leaves room
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------
  // apb master: setup, then access until pready at an edge
  // ----------------------------------------------------------
  task automatic apb(input logic [5:0] idx, input logic wr,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cap_req = 1'b1;
    idle(10);
    presetn <= 1'b1;

    // counter starts near the top, so it wraps within a few steps
    idle(24);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[5], 1'b1)
    apb(`TCC_IDX_CNT_LO, 1'b0, 8'h00, d);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[5], 1'b0)
    apb(`TCC_IDX_FLAGS, 1'b1, 8'hff, d);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[5], 1'b0)
    apb(6'h3f, 1'b0, 8'h00, d);
    `CHK(err, 1'b1)
    $display("test overflow done");

    // rising capture, clear, then a blocked capture
    apb(`TCC_IDX_CTRL, 1'b1, 8'h02, d);
    apb(`TCC_IDX_PINFN, 1'b1, 8'h01, d);
    cap_req <= 1'b0;
    idle(8);
    apb(`TCC_IDX_CNT_LO, 1'b0, 8'h00, pre);
    cap_req <= 1'b1;
    idle(8);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[7], 1'b1)
    apb(`TCC_IDX_CAP_LO, 1'b0, 8'h00, c);
    `CHK((c - pre) inside {8'h02, 8'h03}, 1'b1)
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[7], 1'b0)
    apb(`TCC_IDX_CAP_HI, 1'b0, 8'h00, d);
    cap_req <= 1'b0;
    idle(6);
    cap_req <= 1'b1;
    idle(8);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[7], 1'b0)
    apb(`TCC_IDX_CAP_LO, 1'b0, 8'h00, d);
    `CHK(d, c)
    // falling edge selected
    apb(`TCC_IDX_CTRL, 1'b1, 8'h00, d);
    cap_req <= 1'b0;
    idle(8);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[7], 1'b1)
    apb(`TCC_IDX_CAP_LO, 1'b0, 8'h00, c2);
    // pin disabled: edges never reach the capture logic
    apb(`TCC_IDX_PINFN, 1'b1, 8'h00, d);
    cap_req <= 1'b1;
    idle(6);
    cap_req <= 1'b0;
    idle(8);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[7], 1'b0)
    apb(`TCC_IDX_CAP_LO, 1'b1, ~c2, d);
    apb(`TCC_IDX_CAP_LO, 1'b0, 8'h00, d);
    `CHK(d, c2)
    $display("test capture done");

    // compare drives high, then low after the compare-low write clears the flag; the
    // compare enable waits for a match, as the flag powers up unknown
    apb(`TCC_IDX_CTRL, 1'b1, 8'h01, d);
    apb(`TCC_IDX_PINFN, 1'b1, 8'h02, d);
    for (int lv = 1; lv >= 0; lv--) begin
      apb(`TCC_IDX_CNT_HI, 1'b0, 8'h00, th);
      apb(`TCC_IDX_CNT_LO, 1'b0, 8'h00, d);
      // low byte may wrap between the reads, so the high byte is re-read
      if (d == 8'h00) begin
        apb(`TCC_IDX_CNT_HI, 1'b0, 8'h00, th);
      end
      t = {th, d} + 16'h0010;
      apb(`TCC_IDX_CMP_HI, 1'b1, t[15:8], d);
      apb(`TCC_IDX_CMP_LO, 1'b1, t[7:0], d);
      idle(100);
      `CHK(cmp_wire, lv[0])
      apb(`TCC_IDX_CTRL, 1'b1, {1'b0, lv[0], 5'h00, lv[0]}, d);
      idle(2);
      `CHK(timer_irq, lv[0])
      apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
      `CHK(d[6], 1'b1)
      apb(`TCC_IDX_CTRL, 1'b1, 8'h00, d);
    end
    `CHK(pin_oe, 1'b1)
    // high byte alone holds compares off across a full match
    apb(`TCC_IDX_CTRL, 1'b1, 8'h01, d);
    t = t + 16'h0100;
    apb(`TCC_IDX_CMP_HI, 1'b1, t[15:8], d);
    idle(1100);
    `CHK(cmp_wire, 1'b0)
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    apb(`TCC_IDX_CMP_LO, 1'b1, t[7:0], d);
    apb(`TCC_IDX_FLAGS, 1'b0, 8'h00, d);
    `CHK(d[6], 1'b0)
    $display("test compare done");

    // second reset keeps edge select, compare pair and capture pair
    apb(`TCC_IDX_CTRL, 1'b1, 8'he3, d);
    apb(`TCC_IDX_CTRL, 1'b0, 8'h00, d);
    `CHK(d, 8'he3)
    presetn <= 1'b0;
    idle(3);
    presetn <= 1'b1;
    apb(`TCC_IDX_CTRL, 1'b0, 8'h00, d);
    `CHK(d, 8'h02)
    apb(`TCC_IDX_PINFN, 1'b0, 8'h00, d);
    `CHK(d[1:0], 2'b00)
    `CHK(pin_oe, 1'b0)
    apb(`TCC_IDX_CMP_HI, 1'b0, 8'h00, d);
    `CHK(d, t[15:8])
    apb(`TCC_IDX_CMP_LO, 1'b0, 8'h00, d);
    `CHK(d, t[7:0])
    apb(`TCC_IDX_CAP_LO, 1'b0, 8'h00, d);
    `CHK(d, c2)
    $display("test reset done");
    print_verdict();
  end
endmodule : testbench
